// ---- design/smpp_pkg.sv ----
// constants, opcodes, register map and job states of the serial memory programming port
package smpp_pkg;
	// clock rate and self-timed wait lengths
	localparam int CLK_MHZ = 200;
	localparam int PROG_WAIT_US = 4000; // program_wait_delay
	localparam int ERASE_WAIT_US = 8000; // erase_wait_delay
	localparam int PROG_WAIT_CYC = PROG_WAIT_US * CLK_MHZ;
	localparam int ERASE_WAIT_CYC = ERASE_WAIT_US * CLK_MHZ;
	localparam int TMR_W = 24;
	// instruction frame layout
	localparam int CNT_W = 5;
	localparam logic [CNT_W-1:0] BYTE2_END = 5'h0f;
	localparam logic [CNT_W-1:0] BYTE3_END = 5'h17;
	localparam logic [CNT_W-1:0] LAST_BIT = 5'h1f;
	localparam logic [2:0] BYTE_END = 3'h7;
	// opcodes and sub-codes
	localparam logic [7:0] OP_ENABLE = 8'hac;
	localparam logic [7:0] ENABLE_KEY = 8'h53;
	localparam logic [2:0] SUB_ERASE = 3'h4;
	localparam logic [2:0] SUB_LOCK = 3'h7;
	localparam logic [3:0] OP_FLASH_RD = 4'h2;
	localparam logic [3:0] OP_FLASH_WR = 4'h4;
	localparam logic [7:0] OP_EE_RD = 8'ha0;
	localparam logic [7:0] OP_EE_WR = 8'hc0;
	localparam logic [7:0] OP_SIG_RD = 8'h30;
	localparam int HALF_POS = 3;
	localparam int LOCK1_POS = 1;
	localparam int LOCK2_POS = 2;
	// memory arrays
	localparam int FLASH_AW = 12;
	localparam int FLASH_WORDS = 4096;
	localparam int EE_AW = 9;
	localparam int EE_BYTES = 512;
	localparam logic [7:0] ERASED_BYTE = 8'hff;
	localparam logic [15:0] ERASED_WORD = 16'hffff;
	localparam logic [7:0] POLL_ERASE = 8'h80; // eeprom_poll_erase_value
	localparam logic [7:0] POLL_WRITE = 8'h7f; // eeprom_poll_write_value, also flash poll
	localparam logic [1:0] LOCK_RESET = 2'h3;
	// signature bytes: values are arbitrary
	localparam logic [7:0] SIG0 = 8'h5a;
	localparam logic [7:0] SIG1 = 8'h01;
	localparam logic [7:0] SIG2 = 8'h02;
	// wishbone register map
	localparam int WB_AW = 8;
	localparam logic [WB_AW-1:0] REG_CTRL = 8'h00;
	localparam logic [WB_AW-1:0] REG_STATUS = 8'h04;
	localparam int CTRL_EN_POS = 0;
	localparam logic CTRL_RESET = 1'b1;
	localparam int ST_W = 5;
	// self-timed job kinds, gray ordered
	typedef enum logic [1:0] {JOB_IDLE = 2'h0, JOB_FLASH = 2'h1, JOB_EE = 2'h3, JOB_ERASE = 2'h2} smpp_job_t;
endpackage : smpp_pkg

// ---- design/smpp_port.sv ----
// serial memory programming port: link shifter, decoder, arrays and wishbone registers
`timescale 1ns/1ps
module smpp_port #(
	parameter int unsigned PROG_WAIT_CYC = smpp_pkg::PROG_WAIT_CYC,
	parameter int unsigned ERASE_WAIT_CYC = smpp_pkg::ERASE_WAIT_CYC
) (
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [smpp_pkg::WB_AW-1:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out,
	input wire logic prog_reset_n_in,
	input wire logic sck_in,
	input wire logic serial_in_port_pin_in,
	output logic serial_out_port_pin_out,
	output logic serial_out_port_pin_oe_out
);
	localparam logic [smpp_pkg::TMR_W-1:0] PROG_LOAD = PROG_WAIT_CYC[smpp_pkg::TMR_W-1:0];
	localparam logic [smpp_pkg::TMR_W-1:0] ERASE_LOAD = ERASE_WAIT_CYC[smpp_pkg::TMR_W-1:0];

	logic [2:0] pins_s;
	logic rst_pin_n_s;
	logic mosi_s;
	logic sck_s;
	logic sck_d;
	logic ctrl_en;
	logic active;
	logic sck_rise;
	logic sck_fall;
	logic frame_done;
	logic [31:0] shift_q;
	logic [31:0] shift_in;
	logic [smpp_pkg::CNT_W-1:0] bit_cnt;
	logic [7:0] out_byte;
	logic miso_q;
	logic oe_q;
	logic prog_en;
	logic [1:0] lock;
	smpp_pkg::smpp_job_t job_q;
	logic [smpp_pkg::FLASH_AW-1:0] job_addr;
	logic [7:0] job_data;
	logic job_half;
	logic tmr_start;
	logic [smpp_pkg::TMR_W-1:0] tmr_load;
	logic tmr_busy;
	logic tmr_first;
	logic tmr_mid;
	logic tmr_done;
	logic [15:0] flash_mem [smpp_pkg::FLASH_WORDS];
	logic [7:0] ee_mem [smpp_pkg::EE_BYTES];
	logic [7:0] r1;
	logic [7:0] r2;
	logic [7:0] r3;
	logic [7:0] f1;
	logic [7:0] f2;
	logic [7:0] f3;
	logic [7:0] f4;
	logic [smpp_pkg::FLASH_AW-1:0] fl_addr_r;
	logic [smpp_pkg::EE_AW-1:0] ee_addr_r;
	logic [15:0] fl_word;
	logic fl_rd;
	logic ee_rd;
	logic sig_rd;
	logic fl_hit;
	logic ee_hit;
	logic is_rd;
	logic [7:0] rd_byte;
	logic next_sck_d;
	logic [31:0] next_shift;
	logic [smpp_pkg::CNT_W-1:0] next_bit_cnt;
	logic [7:0] next_out_byte;
	logic next_miso;
	logic next_oe;
	logic next_prog_en;
	logic [1:0] next_lock;
	smpp_pkg::smpp_job_t next_job;
	logic [smpp_pkg::FLASH_AW-1:0] next_job_addr;
	logic [7:0] next_job_data;
	logic next_job_half;
	logic next_ack;
	logic [31:0] next_dat;
	logic next_ctrl_en;

	// reset pin, data and clock of the link all cross in; pin idles high (not programming)
	smpp_sync #(.W(3), .INIT(3'h4)) u_sync (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.async_in({prog_reset_n_in, serial_in_port_pin_in, sck_in}),
		.sync_out(pins_s)
	);
	assign rst_pin_n_s = pins_s[2];
	assign mosi_s = pins_s[1];
	assign sck_s = pins_s[0];

	smpp_wait_timer u_timer (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.start_in(tmr_start),
		.load_in(tmr_load),
		.busy_out(tmr_busy),
		.first_half_out(tmr_first),
		.mid_out(tmr_mid),
		.done_out(tmr_done)
	);

	// edges are found only if each clock phase spans at least one cycle
	assign active = !rst_pin_n_s && ctrl_en;
	assign sck_rise = active && sck_s && !sck_d;
	assign sck_fall = active && !sck_s && sck_d;
	assign shift_in = {shift_q[30:0], mosi_s};
	assign frame_done = sck_rise && bit_cnt == smpp_pkg::LAST_BIT;

	// byte views: first three bytes at byte three end, all four at frame end
	assign r1 = shift_in[23:16];
	assign r2 = shift_in[15:8];
	assign r3 = shift_in[7:0];
	assign f1 = shift_in[31:24];
	assign f2 = shift_in[23:16];
	assign f3 = shift_in[15:8];
	assign f4 = shift_in[7:0];

	// read decode, with polling answers while the addressed byte is busy
	assign fl_addr_r = {r2[3:0], r3};
	assign ee_addr_r = {r2[0], r3};
	assign fl_word = flash_mem[fl_addr_r];
	assign fl_rd = (r1[7:4] == smpp_pkg::OP_FLASH_RD);
	assign ee_rd = (r1 == smpp_pkg::OP_EE_RD);
	assign sig_rd = (r1 == smpp_pkg::OP_SIG_RD);
	assign fl_hit = fl_rd && job_q == smpp_pkg::JOB_FLASH && job_addr == fl_addr_r
		&& job_half == r1[smpp_pkg::HALF_POS];
	assign ee_hit = ee_rd && job_q == smpp_pkg::JOB_EE && job_addr[smpp_pkg::EE_AW-1:0] == ee_addr_r;
	assign is_rd = prog_en && (fl_rd || ee_rd || sig_rd);

	// read data mux
	always_comb
	begin
		rd_byte = r3;
		if (fl_hit)
			rd_byte = smpp_pkg::POLL_WRITE;
		else if (fl_rd)
			rd_byte = r1[smpp_pkg::HALF_POS] ? fl_word[15:8] : fl_word[7:0];
		else if (ee_hit)
			rd_byte = tmr_first ? smpp_pkg::POLL_ERASE : smpp_pkg::POLL_WRITE;
		else if (ee_rd)
			rd_byte = ee_mem[ee_addr_r];
		else if (sig_rd)
		begin
			case (r3[1:0])
				2'h0: rd_byte = smpp_pkg::SIG0;
				2'h1: rd_byte = smpp_pkg::SIG1;
				default: rd_byte = smpp_pkg::SIG2;
			endcase
		end
	end

	// link shifter: a high reset pin drops any partial frame so the programmer can resync
	always_comb
	begin
		next_sck_d = sck_s;
		next_shift = shift_q;
		next_bit_cnt = bit_cnt;
		next_out_byte = out_byte;
		next_miso = miso_q;
		next_oe = active;
		if (!active)
		begin
			next_shift = '0;
			next_bit_cnt = '0;
			next_out_byte = '0;
			next_miso = 1'b0;
		end
		else if (sck_rise)
		begin
			next_shift = shift_in;
			next_bit_cnt = bit_cnt + 5'h01;
			if (bit_cnt[2:0] == smpp_pkg::BYTE_END)
			begin
				if (bit_cnt == smpp_pkg::BYTE3_END && is_rd)
					next_out_byte = rd_byte;
				else
					next_out_byte = shift_in[7:0];
			end
		end
		else if (sck_fall)
		begin
			next_miso = out_byte[7];
			next_out_byte = {out_byte[6:0], 1'b0};
		end
	end

	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			sck_d <= 1'b0;
			shift_q <= '0;
			bit_cnt <= '0;
			out_byte <= '0;
			miso_q <= 1'b0;
			oe_q <= 1'b0;
		end
		else
		begin
			sck_d <= next_sck_d;
			shift_q <= next_shift;
			bit_cnt <= next_bit_cnt;
			out_byte <= next_out_byte;
			miso_q <= next_miso;
			oe_q <= next_oe;
		end
	end
	assign serial_out_port_pin_out = miso_q;
	assign serial_out_port_pin_oe_out = oe_q;

	// frame decode and job control; an erase, lock or write frame arriving while a job runs is refused
	always_comb
	begin
		next_prog_en = prog_en;
		next_lock = lock;
		next_job = job_q;
		next_job_addr = job_addr;
		next_job_data = job_data;
		next_job_half = job_half;
		tmr_start = 1'b0;
		tmr_load = PROG_LOAD;
		if (tmr_done)
		begin
			next_job = smpp_pkg::JOB_IDLE;
			if (job_q == smpp_pkg::JOB_ERASE)
				next_lock = smpp_pkg::LOCK_RESET;
		end
		if (rst_pin_n_s)
			next_prog_en = 1'b0;
		else if (frame_done)
		begin
			if (f1 == smpp_pkg::OP_ENABLE && f2 == smpp_pkg::ENABLE_KEY)
				next_prog_en = 1'b1;
			else if (prog_en && job_q == smpp_pkg::JOB_IDLE)
			begin
				if (f1 == smpp_pkg::OP_ENABLE && f2[7:5] == smpp_pkg::SUB_ERASE)
				begin
					next_job = smpp_pkg::JOB_ERASE;
					tmr_start = 1'b1;
					tmr_load = ERASE_LOAD;
				end
				else if (f1 == smpp_pkg::OP_ENABLE && f2[7:5] == smpp_pkg::SUB_LOCK)
					next_lock = lock & {f2[smpp_pkg::LOCK2_POS], f2[smpp_pkg::LOCK1_POS]};
				else if (f1[7:4] == smpp_pkg::OP_FLASH_WR)
				begin
					next_job = smpp_pkg::JOB_FLASH;
					next_job_addr = {f2[3:0], f3};
					next_job_half = f1[smpp_pkg::HALF_POS];
					next_job_data = f4;
					tmr_start = 1'b1;
				end
				else if (f1 == smpp_pkg::OP_EE_WR)
				begin
					next_job = smpp_pkg::JOB_EE;
					next_job_addr = {3'h0, f2[0], f3};
					next_job_half = 1'b0;
					next_job_data = f4;
					tmr_start = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			prog_en <= 1'b0;
			lock <= smpp_pkg::LOCK_RESET;
			job_q <= smpp_pkg::JOB_IDLE;
			job_addr <= '0;
			job_data <= '0;
			job_half <= 1'b0;
		end
		else
		begin
			prog_en <= next_prog_en;
			lock <= next_lock;
			job_q <= next_job;
			job_addr <= next_job_addr;
			job_data <= next_job_data;
			job_half <= next_job_half;
		end
	end

	// arrays change only at the timed points of a job; wide reset keeps reads defined
	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			for (int i = 0; i < smpp_pkg::FLASH_WORDS; i++)
				flash_mem[i] <= smpp_pkg::ERASED_WORD;
			for (int i = 0; i < smpp_pkg::EE_BYTES; i++)
				ee_mem[i] <= smpp_pkg::ERASED_BYTE;
		end
		else if (job_q == smpp_pkg::JOB_ERASE && tmr_done)
		begin
			for (int i = 0; i < smpp_pkg::FLASH_WORDS; i++)
				flash_mem[i] <= smpp_pkg::ERASED_WORD;
			for (int i = 0; i < smpp_pkg::EE_BYTES; i++)
				ee_mem[i] <= smpp_pkg::ERASED_BYTE;
		end
		else if (job_q == smpp_pkg::JOB_EE && tmr_done)
			ee_mem[job_addr[smpp_pkg::EE_AW-1:0]] <= job_data;
		else if (job_q == smpp_pkg::JOB_EE && tmr_mid)
			ee_mem[job_addr[smpp_pkg::EE_AW-1:0]] <= smpp_pkg::ERASED_BYTE;
		else if (job_q == smpp_pkg::JOB_FLASH && tmr_done)
		begin
			if (job_half)
				flash_mem[job_addr][15:8] <= job_data;
			else
				flash_mem[job_addr][7:0] <= job_data;
		end
	end

	// wishbone slave: one wait state, unmapped reads give zero, unmapped writes vanish
	always_comb
	begin
		next_ack = wb_cyc_in && wb_stb_in && !wb_ack_out;
		next_dat = wb_dat_out;
		next_ctrl_en = ctrl_en;
		if (next_ack && !wb_we_in)
		begin
			if (wb_adr_in == smpp_pkg::REG_CTRL)
				next_dat = {31'h0, ctrl_en};
			else if (wb_adr_in == smpp_pkg::REG_STATUS)
				next_dat = {27'h0, tmr_busy && tmr_first, lock[1], lock[0], tmr_busy, prog_en};
			else
				next_dat = '0;
		end
		// a write lands only at the edge where the master samples ack high
		else if (wb_ack_out && wb_cyc_in && wb_stb_in && wb_we_in
			&& wb_adr_in == smpp_pkg::REG_CTRL && wb_sel_in[0])
			next_ctrl_en = wb_dat_in[smpp_pkg::CTRL_EN_POS];
	end

	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			wb_ack_out <= 1'b0;
			wb_dat_out <= '0;
			ctrl_en <= smpp_pkg::CTRL_RESET;
		end
		else
		begin
			wb_ack_out <= next_ack;
			wb_dat_out <= next_dat;
			ctrl_en <= next_ctrl_en;
		end
	end

	// checks on the link, decoder and arrays
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);

	sample_on_rise_a: assert property (sck_rise |=> shift_q[0] == $past(mosi_s))
		else $error("serial input not sampled on clock rise");
	shift_on_fall_a: assert property (sck_fall |=> miso_q == $past(out_byte[7]) && oe_q)
		else $error("serial output not shifted on clock fall");
	echo_byte_two_a: assert property (sck_rise && bit_cnt == smpp_pkg::BYTE2_END
		|=> out_byte == $past(shift_in[7:0]))
		else $error("byte two not echoed");
	enable_gate_a: assert property ($rose(prog_en) |-> $past(frame_done) && !$past(rst_pin_n_s))
		else $error("enable taken outside a low reset frame");
	reject_locked_a: assert property (frame_done && !prog_en && job_q == smpp_pkg::JOB_IDLE
		|=> job_q == smpp_pkg::JOB_IDLE)
		else $error("job started before enable");
	erase_fill_a: assert property (job_q == smpp_pkg::JOB_ERASE && tmr_done |=> flash_mem[0]
		== smpp_pkg::ERASED_WORD && ee_mem[0] == smpp_pkg::ERASED_BYTE && lock == smpp_pkg::LOCK_RESET)
		else $error("chip erase left data");
	ee_auto_erase_a: assert property (job_q == smpp_pkg::JOB_EE && tmr_mid && !tmr_done
		|=> ee_mem[$past(job_addr[smpp_pkg::EE_AW-1:0])] == smpp_pkg::ERASED_BYTE)
		else $error("eeprom byte not auto-erased");
	ee_poll_a: assert property (sck_rise && bit_cnt == smpp_pkg::BYTE3_END && is_rd && ee_hit
		|=> out_byte == ($past(tmr_first) ? smpp_pkg::POLL_ERASE : smpp_pkg::POLL_WRITE))
		else $error("wrong eeprom poll value");
	flash_poll_a: assert property (sck_rise && bit_cnt == smpp_pkg::BYTE3_END && is_rd && fl_hit
		|=> out_byte == smpp_pkg::POLL_WRITE)
		else $error("wrong flash poll value");
	lock_write_a: assert property (frame_done && prog_en && job_q == smpp_pkg::JOB_IDLE && !tmr_done
		&& f1 == smpp_pkg::OP_ENABLE && f2[7:5] == smpp_pkg::SUB_LOCK
		|=> lock == ($past(lock) & $past({f2[smpp_pkg::LOCK2_POS], f2[smpp_pkg::LOCK1_POS]})))
		else $error("lock bits wrong after write");
	frame_wrap_a: assert property (frame_done |=> bit_cnt == '0 ##1 !sck_rise[*2])
		else $error("frame counter did not wrap");

	enable_seen_c: cover property ($rose(prog_en));
	erase_done_c: cover property (job_q == smpp_pkg::JOB_ERASE && tmr_done);
	ee_write_done_c: cover property (job_q == smpp_pkg::JOB_EE && tmr_done);
	flash_poll_c: cover property (sck_rise && bit_cnt == smpp_pkg::BYTE3_END && is_rd && fl_hit);
endmodule : smpp_port

// ---- design/smpp_sync.sv ----
// two flip-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module smpp_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta;

	// first stage feeds only the second stage
	generate
		for (genvar i = 0; i < W; i++)
		begin : g_bit
			always_ff @(posedge mclk_in or negedge rst_n_in)
			begin
				if (!rst_n_in)
				begin
					meta[i] <= INIT[i];
					sync_out[i] <= INIT[i];
				end
				else
				begin
					meta[i] <= async_in[i];
					sync_out[i] <= meta[i];
				end
			end
		end
	endgenerate
endmodule : smpp_sync

// ---- design/smpp_wait_timer.sv ----
// self-timed wait counter with mid-point and done pulses
`timescale 1ns/1ps
module smpp_wait_timer (
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire logic start_in,
	input wire logic [smpp_pkg::TMR_W-1:0] load_in,
	output logic busy_out,
	output logic first_half_out,
	output logic mid_out,
	output logic done_out
);
	localparam logic [smpp_pkg::TMR_W-1:0] ONE = {{(smpp_pkg::TMR_W-1){1'b0}}, 1'b1};
	logic [smpp_pkg::TMR_W-1:0] cnt;
	logic [smpp_pkg::TMR_W-1:0] half;
	logic [smpp_pkg::TMR_W-1:0] next_cnt;
	logic [smpp_pkg::TMR_W-1:0] next_half;

	// a start while counting is dropped; the caller never issues one
	always_comb
	begin
		next_cnt = cnt;
		next_half = half;
		if (start_in && cnt == '0)
		begin
			next_cnt = load_in;
			next_half = {1'b0, load_in[smpp_pkg::TMR_W-1:1]};
		end
		else if (cnt != '0)
			next_cnt = cnt - ONE;
	end

	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			cnt <= '0;
			half <= '0;
		end
		else
		begin
			cnt <= next_cnt;
			half <= next_half;
		end
	end

	// status and pulses
	assign busy_out = (cnt != '0);
	assign first_half_out = (cnt > half);
	assign mid_out = busy_out && (cnt == half + ONE);
	assign done_out = (cnt == ONE);
endmodule : smpp_wait_timer

// ---- dv/serial_memory_programming_port_tb.sv ----
// self-checking bench: wishbone and programmer traffic against a behavioural model
`timescale 1ns/1ps
module serial_memory_programming_port_tb;
	localparam int PROG_CYC = 1600; // shortened waits keep the run brief
	localparam int ERASE_CYC = 400;
	logic mclk_in;
	logic rst_n_in;
	logic cyc;
	logic stb;
	logic we;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat;
	logic [31:0] rdat;
	logic ack;
	logic sck;
	logic mosi;
	logic miso;
	logic oe;
	logic prst_n;
	int miscompares;
	int tests_run;
	int unsigned seed;
	logic [15:0] m_fl [int];
	logic [7:0] m_ee [int];
	logic [31:0] q;
	logic [31:0] r;
	logic [15:0] w;
	logic [11:0] fa;
	logic [8:0] ea;
	logic [7:0] d;

	smpp_port #(.PROG_WAIT_CYC(PROG_CYC), .ERASE_WAIT_CYC(ERASE_CYC)) uut (
		.mclk_in(mclk_in), .rst_n_in(rst_n_in), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
		.wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
		.prog_reset_n_in(prst_n), .sck_in(sck), .serial_in_port_pin_in(mosi),
		.serial_out_port_pin_out(miso), .serial_out_port_pin_oe_out(oe));
	smpp_programmer prog (.mclk_in(mclk_in), .miso_in(miso), .sck_out(sck), .mosi_out(mosi),
		.prog_reset_n_out(prst_n));

	// 200 MHz clock
	initial
	begin
		mclk_in = 1'b0;
		forever #2.5 mclk_in = ~mclk_in;
	end

	function int unsigned rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			$display("ERROR %s expected %h seen %h", what, exp, seen);
			miscompares++;
		end
	endtask : check

	// classic single cycle, held until ack is sampled high, then one idle cycle
	task automatic wb(input logic wr, input logic [7:0] a, input logic [31:0] dt, output logic [31:0] rd);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= wr;
		adr <= a;
		wdat <= dt;
		do
		begin
			@(posedge mclk_in);
			n++;
		end
		while (ack !== 1'b1 && n < 64);
		if (n >= 64)
			miscompares++;
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge mclk_in);
	endtask : wb

	// busy flag polled with a bound rather than a fixed wait
	task automatic wait_idle();
		for (int n = 0; n < 2000; n++)
		begin
			wb(1'b0, smpp_pkg::REG_STATUS, 32'h0, q);
			if (q[1] === 1'b0)
				return;
		end
		miscompares++; // busy flag never cleared: counts as a mismatch
	endtask : wait_idle

	function automatic logic [15:0] fl(input logic [11:0] a);
		return m_fl.exists(a) ? m_fl[a] : 16'hffff;
	endfunction : fl

	task automatic results();
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : results

	// main sequence
	initial
	begin
		rst_n_in = 1'b0;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		sel = 4'hf;
		wdat = 32'h0;
		seed = 70;
		miscompares = 0;
		tests_run = 0;
		repeat (16) @(posedge mclk_in);
		rst_n_in <= 1'b1;
		repeat (200) @(posedge mclk_in); // power-up wait, scaled down
		wb(1'b0, smpp_pkg::REG_STATUS, 32'h0, q);
		check("status reset", q, 32'h0000000c);
		wb(1'b1, 8'h08, rnd(), q);
		wb(1'b0, 8'h08, 32'h0, q);
		check("unmapped read", q, 32'h0);
		wb(1'b0, smpp_pkg::REG_CTRL, 32'h0, q);
		check("ctrl reset", q, 32'h1);
		wb(1'b1, smpp_pkg::REG_CTRL, 32'h0, q);
		repeat (4) @(posedge mclk_in);
		check("oe off", {31'h0, oe}, 32'h0);
		wb(1'b1, smpp_pkg::REG_CTRL, 32'h1, q);
		repeat (6) @(posedge mclk_in);
		check("oe on", {31'h0, oe}, 32'h1);
		// a write before enable must leave the array blank
		fa = 12'(rnd());
		prog.frame({8'h48, 4'h0, fa, 8'h3c}, r);
		prog.enable(r);
		check("enable echo", {24'h0, r[15:8]}, 32'h53);
		wb(1'b0, smpp_pkg::REG_STATUS, 32'h0, q);
		check("enabled", {31'h0, q[0]}, 32'h1);
		wait_idle();
		prog.frame({8'h28, 4'h0, fa, 8'h00}, r);
		check("refused write", {24'h0, r[7:0]}, 32'hff);
		// both halves of program memory, polled then read back
		for (int h = 0; h < 2; h++)
		begin
			fa = 12'(rnd());
			d = 8'h01 + 8'(rnd() % 125); // keeps clear of the poll values
			prog.frame({4'h4, 1'(h), 3'h0, 4'h0, fa, d}, r);
			w = fl(fa);
			w[h*8 +: 8] = d;
			m_fl[fa] = w;
			prog.frame({4'h2, 1'(h), 3'h0, 4'h0, fa, 8'h00}, r);
			check("flash poll", {24'h0, r[7:0]}, 32'h7f);
			check("byte four echo", {24'h0, r[31:24]}, {24'h0, d});
			check("byte one echo", {24'h0, r[23:16]}, {24'h0, 4'h2, 1'(h), 3'h0});
			wait_idle();
			prog.frame({4'h2, 1'(h), 3'h0, 4'h0, fa, 8'h00}, r);
			check("flash read", {24'h0, r[7:0]}, {24'h0, w[h*8 +: 8]});
		end
		// eeprom twice on one address; second value sets bits the first cleared
		ea = 9'(rnd());
		d = 8'h01 + 8'(rnd() % 125);
		for (int k = 0; k < 2; k++)
		begin
			prog.frame({8'hc0, 7'h0, ea, d}, r);
			m_ee[ea] = d;
			wb(1'b0, smpp_pkg::REG_STATUS, 32'h0, q);
			check("ee erase phase", {30'h0, q[4], q[1]}, 32'h3);
			prog.frame({8'ha0, 7'h0, ea, 8'h00}, r);
			check("ee poll erase", {24'h0, r[7:0]}, 32'h80);
			prog.frame({8'ha0, 7'h0, ea, 8'h00}, r);
			check("ee poll write", {24'h0, r[7:0]}, 32'h7f);
			wait_idle();
			prog.frame({8'ha0, 7'h0, ea, 8'h00}, r);
			check("ee read", {24'h0, r[7:0]}, {24'h0, m_ee[ea]});
			d = ~d;
		end
		// lock bit one programmed, lock bit two sent as one
		prog.frame({8'hac, 8'he4, 16'h0}, r);
		wb(1'b0, smpp_pkg::REG_STATUS, 32'h0, q);
		check("lock bits", {30'h0, q[3:2]}, 32'h2);
		// chip erase, then restart the session
		prog.frame({8'hac, 8'h80, 16'h0}, r);
		m_fl.delete();
		m_ee.delete();
		wait_idle();
		wb(1'b0, smpp_pkg::REG_STATUS, 32'h0, q);
		check("locks erased", {30'h0, q[3:2]}, 32'h3);
		prog.set_reset(1'b1);
		prog.set_reset(1'b0);
		prog.enable(r);
		check("re-enable echo", {24'h0, r[15:8]}, 32'h53);
		prog.frame({8'h28, 4'h0, fa, 8'h00}, r);
		w = fl(fa);
		check("flash erased", {24'h0, r[7:0]}, {24'h0, w[15:8]});
		prog.frame({8'ha0, 7'h0, ea, 8'h00}, r);
		check("ee erased", {24'h0, r[7:0]}, 32'hff);
		// signature bytes, selected by the low bits of byte three
		for (int k = 0; k < 3; k++)
		begin
			prog.frame({smpp_pkg::OP_SIG_RD, 8'h00, 6'h0, 2'(k), 8'h00}, r);
			d = (k == 0) ? smpp_pkg::SIG0 : ((k == 1) ? smpp_pkg::SIG1 : smpp_pkg::SIG2);
			check("signature", {24'h0, r[7:0]}, {24'h0, d});
		end
		// reset pin high: session ends and enable is not accepted
		prog.set_reset(1'b1);
		prog.frame({8'hac, 8'h53, 16'h0}, r);
		wb(1'b0, smpp_pkg::REG_STATUS, 32'h0, q);
		check("enable refused", {31'h0, q[0]}, 32'h0);
		check("oe released", {31'h0, oe}, 32'h0);
		results();
	end

	// watchdog: about three times the expected run of some 20k cycles
	initial
	begin
		repeat (60000) @(posedge mclk_in);
		miscompares++;
		results();
	end
endmodule : serial_memory_programming_port_tb

// ---- dv/smpp_programmer.sv ----
// behavioural in-system programmer: drives link clock, serial data and reset pin
`timescale 1ns/1ps
module smpp_programmer (
	input wire logic mclk_in,
	input wire logic miso_in,
	output logic sck_out,
	output logic mosi_out,
	output logic prog_reset_n_out
);
	// reset pin and link clock held low from power-up
	initial
	begin
		sck_out = 1'b0;
		mosi_out = 1'b0;
		prog_reset_n_out = 1'b0;
	end

	// one whole frame, msb first; 8 mclk per phase keeps both phases over two cycles
	task automatic frame(input logic [31:0] cmd, output logic [31:0] resp);
		for (int i = 31; i >= 0; i--)
		begin
			@(posedge mclk_in);
			sck_out <= 1'b0;
			mosi_out <= cmd[i];
			repeat (7) @(posedge mclk_in);
			@(negedge mclk_in);
			resp[i] = miso_in;
			@(posedge mclk_in);
			sck_out <= 1'b1;
			repeat (7) @(posedge mclk_in);
		end
		@(posedge mclk_in);
		sck_out <= 1'b0;
		mosi_out <= ~cmd[0]; // data line does not keep the last bit
	endtask : frame

	// enable with resync: extra clock pulse after a missing echo, give up after 32 tries
	task automatic enable(output logic [31:0] resp);
		for (int n = 0; n < 32; n++)
		begin
			frame({smpp_pkg::OP_ENABLE, smpp_pkg::ENABLE_KEY, 16'h0000}, resp);
			if (resp[15:8] === smpp_pkg::ENABLE_KEY)
				break;
			@(posedge mclk_in);
			sck_out <= 1'b1;
			repeat (8) @(posedge mclk_in);
			sck_out <= 1'b0;
		end
	endtask : enable

	// reset pin level, held long enough for the synchroniser
	task automatic set_reset(input logic hi);
		@(posedge mclk_in);
		prog_reset_n_out <= hi;
		repeat (8) @(posedge mclk_in);
	endtask : set_reset
endmodule : smpp_programmer
